// ===== include/avr_pkg.sv
// Shared constants and types for the verify, recalibrate and password-disable block
package avr_pkg;
	// ----------------------------------------
	// Task file addresses
	// ----------------------------------------
	typedef logic [2:0] avr_tf_addr_t;
	localparam avr_tf_addr_t TF_DATA = 3'h0;
	localparam avr_tf_addr_t TF_ERR = 3'h1;
	localparam avr_tf_addr_t TF_SCNT = 3'h2;
	localparam avr_tf_addr_t TF_SNUM = 3'h3;
	localparam avr_tf_addr_t TF_CYLL = 3'h4;
	localparam avr_tf_addr_t TF_CYLH = 3'h5;
	localparam avr_tf_addr_t TF_DEVH = 3'h6;
	localparam avr_tf_addr_t TF_STAT = 3'h7;
	// ----------------------------------------
	// Opcodes and bit positions
	// ----------------------------------------
	localparam logic [7:0] OP_VFY = 8'h40;
	localparam logic [3:0] OP_RCL_HI = 4'h1;
	localparam logic [7:0] OP_PWDIS = 8'hF6;
	localparam int SB_BSY = 7;
	localparam int SB_RDY = 6;
	localparam int SB_DF = 5;
	localparam int SB_DSC = 4;
	localparam int SB_DRQ = 3;
	localparam int SB_COR = 2;
	localparam int SB_ERR = 0;
	localparam int EB_UNC = 6;
	localparam int EB_ABT = 2;
	localparam int EB_T0N = 1;
	localparam int DEVH_L = 6;
	// ----------------------------------------
	// Reset values, sizes, geometry
	// ----------------------------------------
	localparam logic [7:0] DEVH_RST = 8'hA0;
	localparam logic [8:0] SCNT_FULL = 9'h100;
	localparam logic [7:0] PW_WORDS = 8'h10;
	localparam logic [7:0] SECT_LAST_WORD = 8'hFF;
	localparam logic [7:0] CHS_SPT = 8'h3F;
	localparam logic [3:0] CHS_HMAX = 4'hF;
	// ----------------------------------------
	// State types
	// ----------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_VFY = 5'h02,
		ST_RCL = 5'h04,
		ST_PWD = 5'h08,
		ST_PWC = 5'h10
	} avr_state_t;
	typedef struct packed {
		avr_state_t state;
		logic [7:0] scnt;
		logic [7:0] snum;
		logic [7:0] cyll;
		logic [7:0] cylh;
		logic [7:0] devh;
		logic [7:0] errf;
		logic err_st;
		logic no_retry;
		logic [8:0] remain;
		logic [7:0] wcnt;
		logic pw_sel;
		logic lock_en;
		logic [15:0] rdata;
	} avr_main_t;
	localparam avr_main_t MAIN_RST = '{state: ST_IDLE, devh: DEVH_RST, default: '0};
	typedef struct packed {
		logic [31:0][15:0] words;
		logic [15:0] rdata;
	} avr_mem_t;
	typedef struct packed {
		logic [15:0] held;
		logic valid;
		logic match;
	} avr_chk_t;
endpackage : avr_pkg

// ===== include/avr_pw_if.sv
// Password store and compare signals between the command engine and its helpers
`timescale 1ns/10ps
interface avr_pw_if;
	logic rd_en;
	logic [4:0] rd_addr;
	logic [15:0] rd_data;
	logic wr_en;
	logic [4:0] wr_addr;
	logic [15:0] wr_data;
	logic cmp_clr;
	logic cmp_stb;
	logic [15:0] cmp_word;
	logic cmp_match;
	modport ctl (output rd_en, rd_addr, wr_en, wr_addr, wr_data, cmp_clr, cmp_stb, cmp_word,
		input cmp_match);
	modport mem (input rd_en, rd_addr, wr_en, wr_addr, wr_data, output rd_data);
	modport chk (input cmp_clr, cmp_stb, cmp_word, rd_data, output cmp_match);
endinterface : avr_pw_if

// ===== logic/avr_pw_mem.sv
// Stored user and master passwords, registered read
`timescale 1ns/10ps
module avr_pw_mem (
	input wire logic clk, // Clock
	input wire logic sys_rst, // Async reset
	avr_pw_if.mem pw // Store port
);
	import avr_pkg::*;
	avr_mem_t st_ff;
	avr_mem_t nxt_st;
	assign pw.rd_data = st_ff.rdata;
	always_comb begin
		nxt_st = st_ff;
		if (pw.wr_en) begin
			nxt_st.words[pw.wr_addr] = pw.wr_data;
		end
		if (pw.rd_en) begin
			nxt_st.rdata = st_ff.words[pw.rd_addr];
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule : avr_pw_mem

// ===== logic/avr_pw_chk.sv
// Running word-by-word password comparison
`timescale 1ns/10ps
module avr_pw_chk (
	input wire logic clk, // Clock
	input wire logic sys_rst, // Async reset
	avr_pw_if.chk pw // Compare port
);
	import avr_pkg::*;
	avr_chk_t st_ff;
	avr_chk_t nxt_st;
	assign pw.cmp_match = st_ff.match;
	always_comb begin
		nxt_st = st_ff;
		// Stored word arrives one cycle after the strobe
		nxt_st.valid = pw.cmp_stb;
		if (pw.cmp_stb) begin
			nxt_st.held = pw.cmp_word;
		end
		if (st_ff.valid && (st_ff.held != pw.rd_data)) begin
			nxt_st.match = 1'b0;
		end
		if (pw.cmp_clr) begin
			nxt_st.match = 1'b1;
			nxt_st.valid = 1'b0;
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			// Mismatch after reset, so nothing unlocks by accident
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	AST_MISMATCH_STICKS: assert property (
		(st_ff.valid && st_ff.held != pw.rd_data && !pw.cmp_clr) |=> !pw.cmp_match [*2])
		else $error("password mismatch did not clear match");
endmodule : avr_pw_chk

// ===== logic/avr_cmd_top.sv
// Task-file command engine: read verify, recalibrate, password disable
`timescale 1ns/10ps
module avr_cmd_top (
	input wire logic clk, // Clock
	input wire logic sys_rst, // Async reset
	input wire logic tf_wr, // Task file write strobe
	input wire logic tf_rd, // Task file read strobe
	input wire avr_pkg::avr_tf_addr_t tf_addr, // Task file register address
	input wire logic [15:0] tf_wdata, // Write data
	output logic [15:0] tf_rdata, // Read data, registered
	output logic tf_busy, // Busy flag
	output logic tf_drq, // Data request flag
	output logic med_vfy_req, // Verify request to media
	output logic [27:0] med_vfy_addr, // Sector address to verify
	output logic med_vfy_lba, // Address is linear
	output logic med_no_retry, // Retries disabled
	input wire logic med_vfy_done, // Verify of sector finished
	input wire logic med_vfy_bad, // Sector uncorrectable
	output logic med_recal_req, // Recalibrate request
	input wire logic med_recal_done, // Recalibrate finished
	input wire logic med_recal_fail, // Cylinder zero not reached
	input wire logic pw_load, // Load one stored password word
	input wire logic pw_load_master, // Load target is master
	input wire logic [3:0] pw_load_idx, // Word index in password
	input wire logic [15:0] pw_load_word, // Word value
	input wire logic lock_set, // Lock enabled by a password set
	output logic lock_enabled // Device lock state
);
	import avr_pkg::*;
	avr_main_t st_ff;
	avr_main_t nxt_st;
	avr_pw_if pw();
	logic busy;
	logic drq;
	logic [7:0] status;
	logic cmd_wr;
	logic data_wr;
	logic [27:0] lba_cur;
	logic [27:0] lba_nxt;
	logic [15:0] cyl_nxt;
	logic [8:0] rem_dec;
	logic [7:0] wcnt_m1;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	avr_pw_mem u_mem (
		.clk(clk),
		.sys_rst(sys_rst),
		.pw(pw.mem)
	);
	avr_pw_chk u_chk (
		.clk(clk),
		.sys_rst(sys_rst),
		.pw(pw.chk)
	);
	// ----------------------------------------
	// Derived signals
	// ----------------------------------------
	assign busy = (st_ff.state == ST_VFY) || (st_ff.state == ST_RCL) || (st_ff.state == ST_PWC);
	assign drq = (st_ff.state == ST_PWD);
	always_comb begin
		status = 8'h00;
		status[SB_BSY] = busy;
		status[SB_RDY] = 1'b1;
		status[SB_DSC] = 1'b1;
		status[SB_DRQ] = drq;
		status[SB_ERR] = st_ff.err_st;
	end
	assign cmd_wr = tf_wr && (tf_addr == TF_STAT) && (st_ff.state == ST_IDLE);
	assign data_wr = tf_wr && (tf_addr == TF_DATA) && (st_ff.state == ST_PWD);
	assign lba_cur = {st_ff.devh[3:0], st_ff.cylh, st_ff.cyll, st_ff.snum};
	assign lba_nxt = lba_cur + 28'h0000001;
	assign cyl_nxt = {st_ff.cylh, st_ff.cyll} + 16'h0001;
	assign rem_dec = st_ff.remain - 9'h001;
	assign wcnt_m1 = st_ff.wcnt - 8'h01;
	assign pw.cmp_clr = data_wr && (st_ff.wcnt == 8'h00);
	assign pw.cmp_stb = data_wr && (st_ff.wcnt != 8'h00) && (st_ff.wcnt <= PW_WORDS);
	assign pw.cmp_word = tf_wdata;
	assign pw.rd_en = pw.cmp_stb;
	assign pw.rd_addr = {st_ff.pw_sel, wcnt_m1[3:0]};
	// Store is written only by password set, never by the disable path
	assign pw.wr_en = pw_load;
	assign pw.wr_addr = {pw_load_master, pw_load_idx};
	assign pw.wr_data = pw_load_word;
	assign tf_rdata = st_ff.rdata;
	assign tf_busy = busy;
	assign tf_drq = drq;
	assign med_vfy_req = (st_ff.state == ST_VFY);
	assign med_vfy_addr = lba_cur;
	assign med_vfy_lba = st_ff.devh[DEVH_L];
	assign med_no_retry = st_ff.no_retry;
	assign med_recal_req = (st_ff.state == ST_RCL);
	assign lock_enabled = st_ff.lock_en;
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		if (tf_rd) begin
			unique case (tf_addr)
				TF_DATA: nxt_st.rdata = 16'h0000;
				TF_ERR: nxt_st.rdata = {8'h00, st_ff.errf};
				TF_SCNT: nxt_st.rdata = {8'h00, st_ff.scnt};
				TF_SNUM: nxt_st.rdata = {8'h00, st_ff.snum};
				TF_CYLL: nxt_st.rdata = {8'h00, st_ff.cyll};
				TF_CYLH: nxt_st.rdata = {8'h00, st_ff.cylh};
				TF_DEVH: nxt_st.rdata = {8'h00, st_ff.devh};
				TF_STAT: nxt_st.rdata = {8'h00, status};
			endcase
		end
		unique case (st_ff.state)
			ST_IDLE: begin
				// Writes while busy or in a data phase are dropped
				if (tf_wr) begin
					case (tf_addr)
						TF_SCNT: nxt_st.scnt = tf_wdata[7:0];
						TF_SNUM: nxt_st.snum = tf_wdata[7:0];
						TF_CYLL: nxt_st.cyll = tf_wdata[7:0];
						TF_CYLH: nxt_st.cylh = tf_wdata[7:0];
						TF_DEVH: nxt_st.devh = tf_wdata[7:0];
						default: ;
					endcase
				end
				if (cmd_wr) begin
					nxt_st.errf = 8'h00;
					nxt_st.err_st = 1'b0;
					if (tf_wdata[7:1] == OP_VFY[7:1]) begin
						nxt_st.no_retry = tf_wdata[0];
						nxt_st.remain = (st_ff.scnt == 8'h00) ? SCNT_FULL : {1'b0, st_ff.scnt};
						nxt_st.state = ST_VFY;
					end else if (tf_wdata[7:4] == OP_RCL_HI) begin
						nxt_st.state = ST_RCL;
					end else if (tf_wdata[7:0] == OP_PWDIS) begin
						nxt_st.wcnt = 8'h00;
						nxt_st.state = ST_PWD;
					end else begin
						nxt_st.errf[EB_ABT] = 1'b1;
						nxt_st.err_st = 1'b1;
					end
				end
			end
			ST_VFY: begin
				if (med_vfy_done) begin
					if (med_vfy_bad) begin
						// Address left on the failing sector
						nxt_st.errf[EB_UNC] = 1'b1;
						nxt_st.err_st = 1'b1;
						nxt_st.scnt = st_ff.remain[7:0];
						nxt_st.state = ST_IDLE;
					end else if (st_ff.remain == 9'h001) begin
						nxt_st.remain = 9'h000;
						nxt_st.scnt = 8'h00;
						nxt_st.state = ST_IDLE;
					end else begin
						nxt_st.remain = rem_dec;
						nxt_st.scnt = rem_dec[7:0];
						if (st_ff.devh[DEVH_L]) begin
							{nxt_st.devh[3:0], nxt_st.cylh, nxt_st.cyll, nxt_st.snum} = lba_nxt;
						end else if (st_ff.snum == CHS_SPT) begin
							nxt_st.snum = 8'h01;
							if (st_ff.devh[3:0] == CHS_HMAX) begin
								nxt_st.devh[3:0] = 4'h0;
								{nxt_st.cylh, nxt_st.cyll} = cyl_nxt;
							end else begin
								nxt_st.devh[3:0] = st_ff.devh[3:0] + 4'h1;
							end
						end else begin
							nxt_st.snum = st_ff.snum + 8'h01;
						end
					end
				end
			end
			ST_RCL: begin
				if (med_recal_done) begin
					if (med_recal_fail) begin
						nxt_st.errf[EB_T0N] = 1'b1;
						nxt_st.err_st = 1'b1;
					end
					nxt_st.state = ST_IDLE;
				end
			end
			ST_PWD: begin
				if (data_wr) begin
					if (st_ff.wcnt == 8'h00) begin
						nxt_st.pw_sel = tf_wdata[0];
					end
					nxt_st.wcnt = st_ff.wcnt + 8'h01;
					if (st_ff.wcnt == SECT_LAST_WORD) begin
						nxt_st.state = ST_PWC;
					end
				end
			end
			ST_PWC: begin
				if (pw.cmp_match) begin
					nxt_st.lock_en = 1'b0;
				end else begin
					nxt_st.errf[EB_ABT] = 1'b1;
					nxt_st.err_st = 1'b1;
				end
				nxt_st.state = ST_IDLE;
			end
		endcase
		// A lock request in the same cycle as a disable wins
		if (lock_set) begin
			nxt_st.lock_en = 1'b1;
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= MAIN_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	AST_VFY_NO_DRQ: assert property ((cmd_wr && tf_wdata[7:1] == 7'h20) |=>
		(med_vfy_req && !drq))
		else $error("verify start raised data request or no media request");
	AST_NO_RETRY: assert property ((cmd_wr && tf_wdata[7:1] == 7'h20) |=>
		(med_no_retry == $past(tf_wdata[0])))
		else $error("retry disable does not follow opcode bit");
	AST_ZERO_256: assert property ((cmd_wr && tf_wdata[7:1] == 7'h20 && st_ff.scnt == 8'h00)
		|=> st_ff.remain == 9'h100)
		else $error("zero sector count not taken as 256");
	AST_LBA_MAP: assert property ((med_vfy_req && med_vfy_lba) |->
		(med_vfy_addr[7:0] == st_ff.snum && med_vfy_addr[15:8] == st_ff.cyll
		&& med_vfy_addr[23:16] == st_ff.cylh && med_vfy_addr[27:24] == st_ff.devh[3:0]))
		else $error("linear address assembled wrongly");
	AST_STOP_BAD: assert property ((med_vfy_req && med_vfy_done && med_vfy_bad) |=>
		(!med_vfy_req && $stable(med_vfy_addr) && !busy))
		else $error("verify continued past failing sector");
	AST_SCNT_LEFT: assert property ((med_vfy_req && med_vfy_done && med_vfy_bad) |=>
		st_ff.scnt == $past(st_ff.remain[7:0]))
		else $error("sector count does not show sectors left");
	AST_NEXT_LBA: assert property ((med_vfy_req && med_vfy_done && !med_vfy_bad && med_vfy_lba
		&& st_ff.remain > 9'h001) |=> med_vfy_addr == $past(med_vfy_addr) + 28'h0000001)
		else $error("address did not advance to next sector");
	AST_RCL_REQ: assert property ((cmd_wr && tf_wdata[7:4] == 4'h1) |=> med_recal_req)
		else $error("recalibrate not requested");
	AST_T0N: assert property ((med_recal_req && med_recal_done && med_recal_fail) |=>
		(st_ff.errf[EB_T0N] && status[SB_ERR] && !busy))
		else $error("track zero failure not reported");
	AST_PW_DRQ: assert property ((cmd_wr && tf_wdata[7:0] == 8'hF6) |=>
		(drq && !busy && st_ff.lock_en == $past(st_ff.lock_en)))
		else $error("password disable did not ask for data");
	AST_PW_OK: assert property ((st_ff.state == ST_PWC && pw.cmp_match && !lock_set) |=>
		(!lock_enabled && !st_ff.err_st))
		else $error("matching password did not clear lock");
	AST_PW_BAD: assert property ((st_ff.state == ST_PWC && !pw.cmp_match && !lock_set) |=>
		(lock_enabled == $past(lock_enabled) && st_ff.errf[EB_ABT] && status[SB_ERR]))
		else $error("mismatch changed lock or missed abort");
	AST_END_STAT: assert property ($fell(busy) |->
		(!status[SB_BSY] && !status[SB_DF] && !status[SB_COR] && status[SB_RDY]))
		else $error("end status bits wrong");
	AST_VFY_STEP: assert property ((med_vfy_req && med_vfy_done && !med_vfy_bad
		&& st_ff.remain > 9'h001) |=>
		(med_vfy_req && st_ff.remain == $past(st_ff.remain) - 9'h001))
		else $error("sectors left did not count down");
	AST_VFY_END: assert property ((med_vfy_req && med_vfy_done && !med_vfy_bad
		&& st_ff.remain == 9'h001) |=> (!busy && st_ff.scnt == 8'h00 && $stable(med_vfy_addr)))
		else $error("verify end left count or moved address");
	AST_CHS_WRAP: assert property ((med_vfy_req && med_vfy_done && !med_vfy_bad
		&& !med_vfy_lba && st_ff.remain > 9'h001 && st_ff.snum == CHS_SPT) |=> st_ff.snum == 8'h01)
		else $error("sector number did not wrap at end of track");
	AST_RCL_END: assert property ((med_recal_req && med_recal_done) |=>
		(!med_recal_req && !busy))
		else $error("recalibrate did not finish on done");
	AST_PW_SEL: assert property ((data_wr && st_ff.wcnt == 8'h00) |=>
		(st_ff.pw_sel == $past(tf_wdata[0])))
		else $error("selector not taken from control word");
	AST_PW_MORE: assert property ((data_wr && st_ff.wcnt != SECT_LAST_WORD) |=>
		(drq && !busy))
		else $error("data phase ended before a full sector");
	AST_PW_CHECK: assert property ((data_wr && st_ff.wcnt == SECT_LAST_WORD) |=>
		(busy && !drq))
		else $error("password check did not follow the last data word");
	AST_BAD_OP: assert property ((cmd_wr && tf_wdata[7:1] != 7'h20 && tf_wdata[7:4] != 4'h1
		&& tf_wdata[7:0] != 8'hF6) |=> (!busy && !drq && st_ff.errf[EB_ABT] && status[SB_ERR]))
		else $error("unknown command not aborted");
endmodule : avr_cmd_top

// ===== bench/avr_media_model.sv
// Behavioural media and servo model answering verify and recalibrate requests
`timescale 1ns/10ps
module avr_media_model (
	input wire logic clk, // Clock
	input wire logic sys_rst, // Async reset
	input wire logic [1:0] cfg_delay, // Idle cycles before each answer
	input wire logic cfg_bad_en, // Inject one uncorrectable sector
	input wire logic [27:0] cfg_bad_addr, // Sector that fails
	input wire logic cfg_t0_fail, // Recalibrate misses cylinder 0
	input wire logic med_vfy_req, // Verify request
	input wire logic [27:0] med_vfy_addr, // Sector under verify
	input wire logic med_recal_req, // Recalibrate request
	output logic med_vfy_done, // Sector finished
	output logic med_vfy_bad, // Sector uncorrectable
	output logic med_recal_done, // Recalibrate finished
	output logic med_recal_fail // Cylinder 0 missed
);
	logic [1:0] cnt;
	logic fire;
	assign fire = (cnt == cfg_delay) && !med_vfy_done && !med_recal_done;
	// Qualifiers toggle outside a done pulse, so a stale level never looks valid
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= 2'h0;
			med_vfy_done <= 1'b0;
			med_vfy_bad <= 1'b0;
			med_recal_done <= 1'b0;
			med_recal_fail <= 1'b0;
		end else begin
			med_vfy_done <= med_vfy_req && fire;
			med_recal_done <= med_recal_req && !med_vfy_req && fire;
			med_vfy_bad <= fire ? (cfg_bad_en && med_vfy_addr == cfg_bad_addr) : ~med_vfy_bad;
			med_recal_fail <= fire ? cfg_t0_fail : ~med_recal_fail;
			if (!(med_vfy_req || med_recal_req) || med_vfy_done || med_recal_done || fire) begin
				cnt <= 2'h0;
			end else begin
				cnt <= cnt + 2'h1;
			end
		end
	end
endmodule : avr_media_model

// ===== bench/avr_cmd_top_tb.sv
// Self-checking bench for the verify, recalibrate and password-disable engine
`timescale 1ns/10ps
module avr_cmd_top_tb;
	import avr_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic tf_wr = 1'b0;
	logic tf_rd = 1'b0;
	avr_tf_addr_t tf_addr = TF_DATA;
	logic [15:0] tf_wdata = 16'h0000;
	logic [15:0] tf_rdata;
	logic tf_busy, tf_drq, med_vfy_req, med_vfy_lba, med_no_retry, med_recal_req, lock_enabled;
	logic med_vfy_done, med_vfy_bad, med_recal_done, med_recal_fail;
	logic [27:0] med_vfy_addr;
	logic [27:0] bad_addr = 28'h0000000;
	logic pw_load = 1'b0, pw_master = 1'b0, lock_set = 1'b0, bad_en = 1'b0, t0_fail = 1'b0;
	logic [3:0] pw_idx = 4'h0;
	logic [15:0] pw_word = 16'h0000;
	logic [1:0] dly = 2'h1;
	logic [7:0] v;
	int fail_count = 0;
	int tests_run = 0;
	int exp_q[$];
	int upw[16], mpw[16];
	bit lock = 1'b0;
	always #2.5 clk = ~clk;

	avr_cmd_top DUT (.clk(clk), .sys_rst(sys_rst), .tf_wr(tf_wr), .tf_rd(tf_rd),
		.tf_addr(tf_addr), .tf_wdata(tf_wdata), .tf_rdata(tf_rdata), .tf_busy(tf_busy),
		.tf_drq(tf_drq), .med_vfy_req(med_vfy_req), .med_vfy_addr(med_vfy_addr),
		.med_vfy_lba(med_vfy_lba), .med_no_retry(med_no_retry), .med_vfy_done(med_vfy_done),
		.med_vfy_bad(med_vfy_bad), .med_recal_req(med_recal_req),
		.med_recal_done(med_recal_done), .med_recal_fail(med_recal_fail), .pw_load(pw_load),
		.pw_load_master(pw_master), .pw_load_idx(pw_idx), .pw_load_word(pw_word),
		.lock_set(lock_set), .lock_enabled(lock_enabled));
	avr_media_model MEDIA (.clk(clk), .sys_rst(sys_rst), .cfg_delay(dly), .cfg_bad_en(bad_en),
		.cfg_bad_addr(bad_addr), .cfg_t0_fail(t0_fail), .med_vfy_req(med_vfy_req),
		.med_vfy_addr(med_vfy_addr), .med_recal_req(med_recal_req),
		.med_vfy_done(med_vfy_done), .med_vfy_bad(med_vfy_bad),
		.med_recal_done(med_recal_done), .med_recal_fail(med_recal_fail));

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic summarize();
		$display("Checks run %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk

	// Idle cycle after each write keeps the strobe from being reassigned in one step
	task automatic wr(input avr_tf_addr_t a, input logic [15:0] d);
		tf_wr = 1'b1;
		tf_addr = a;
		tf_wdata = d;
		@(posedge clk);
		#1 tf_wr = 1'b0;
		@(posedge clk);
		#1;
	endtask : wr

	task automatic rd(input avr_tf_addr_t a, output logic [7:0] q);
		tf_rd = 1'b1;
		tf_addr = a;
		@(posedge clk);
		#1 tf_rd = 1'b0;
		q = tf_rdata[7:0];
		@(posedge clk);
		#1;
	endtask : rd

	task automatic wait_idle();
		int n;
		n = 0;
		v = 8'h80;
		while (v[SB_BSY] !== 1'b0 && n < 3000) begin
			rd(TF_STAT, v);
			n++;
		end
		if (n >= 3000)
			chk("busy timeout", 1, 0);
	endtask : wait_idle

	function automatic int nxt(input int a, input bit lba);
		if (lba || a[7:0] < CHS_SPT)
			return (a + 1) & 32'h0FFFFFFF;
		if (a[27:24] < CHS_HMAX)
			return {a[27:24] + 4'h1, a[23:8], 8'h01};
		return {4'h0, a[23:8] + 16'h0001, 8'h01};
	endfunction : nxt

	always @(posedge clk) begin
		if (med_vfy_req === 1'b1 && med_vfy_done === 1'b1) begin
			chk("vfy addr", med_vfy_addr, exp_q.size() ? exp_q.pop_front() : -1);
			chk("vfy drq", tf_drq, 0);
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic run_vfy(input bit r0, input bit lba, input logic [7:0] sc, input int bk);
		int n, a, k, last;
		logic [7:0] r;
		n = (sc == 8'h00) ? 256 : sc;
		a = {4'($urandom), 16'($urandom), lba ? 8'($urandom) : 8'($urandom_range(63, 1))};
		wr(TF_SCNT, sc);
		wr(TF_SNUM, a[7:0]);
		wr(TF_CYLL, a[15:8]);
		wr(TF_CYLH, a[23:16]);
		wr(TF_DEVH, {1'b1, lba, 2'b10, a[27:24]});
		for (k = 1; k <= n; k++) begin
			exp_q.push_back(a);
			if (k == bk)
				bad_addr = a[27:0];
			if (k == (bk ? bk : n))
				last = a;
			a = nxt(a, lba);
		end
		bad_en = (bk != 0);
		wr(TF_STAT, {7'h20, r0});
		chk("no retry", med_no_retry, r0);
		chk("lba", med_vfy_lba, lba);
		wait_idle();
		chk("vfy status", v, bk ? 8'h51 : 8'h50);
		chk("unverified", exp_q.size(), bk ? n - bk : 0);
		exp_q.delete();
		rd(TF_ERR, r);
		chk("vfy error", r, bk ? 8'h40 : 8'h00);
		rd(TF_SCNT, r);
		chk("vfy count", r, bk ? 8'(n - bk + 1) : 8'h00);
		rd(TF_SNUM, r);
		chk("last snum", r, last[7:0]);
		rd(TF_CYLL, r);
		chk("last cyll", r, last[15:8]);
		rd(TF_CYLH, r);
		chk("last cylh", r, last[23:16]);
		rd(TF_DEVH, r);
		chk("last head", r[3:0], last[27:24]);
	endtask : run_vfy

	task automatic pw_cmd(input logic [2:0] c);
		int w;
		logic [7:0] r;
		wr(TF_STAT, OP_PWDIS);
		chk("pw drq", tf_drq, 1);
		chk("pw busy", tf_busy, 0);
		wr(TF_DATA, {15'($urandom), c[2]});
		for (w = 0; w < 16; w++)
			wr(TF_DATA, 16'(c[1] ? mpw[w] : upw[w]) ^ {15'h0000, c[0] && w == 15});
		for (w = 17; w < 256; w++)
			wr(TF_DATA, 16'($urandom));
		wait_idle();
		if (c[2] == c[1] && !c[0])
			lock = 1'b0;
		chk("pw lock", lock_enabled, lock);
		chk("pw status", v, lock ? 8'h51 : 8'h50);
		rd(TF_ERR, r);
		chk("pw error", r, lock ? 8'h04 : 8'h00);
	endtask : pw_cmd

	initial begin
		int i;
		logic [7:0] sc, r;
		logic [2:0] pw_tab[6];
		pw_tab = '{3'b000, 3'b111, 3'b100, 3'b010, 3'b110, 3'b110};
		void'($urandom(52152));
		repeat (20) @(posedge clk);
		#1 sys_rst = 1'b0;
		@(posedge clk);
		#1;
		rd(TF_STAT, r);
		chk("reset status", r, 8'h50);
		rd(TF_DEVH, r);
		chk("reset devh", r, DEVH_RST);
		wr(TF_ERR, 16'h00FF);
		rd(TF_ERR, r);
		chk("error read only", r, 8'h00);
		chk("reset lock", lock_enabled, 0);
		// Unknown opcode must abort without going busy
		wr(TF_STAT, 16'h0091);
		chk("bad op busy", tf_busy, 0);
		rd(TF_STAT, r);
		chk("bad op status", r, 8'h51);
		rd(TF_ERR, r);
		chk("bad op error", r, 8'h04);
		$display("done: reset values");
		for (i = 0; i < 8; i++) begin
			dly = 2'($urandom_range(2, 0));
			sc = (i < 2) ? 8'(i) : 8'($urandom_range(40, 2));
			run_vfy(i[2], i[0], sc, (i > 1 && i[1]) ? $urandom_range(sc, 1) : 0);
		end
		$display("done: read verify");
		dly = 2'h2;
		for (i = 0; i < 16; i++) begin
			t0_fail = 1'($urandom);
			wr(TF_STAT, {4'h1, 4'(i)});
			chk("recal req", med_recal_req, 1);
			chk("recal busy", tf_busy, 1);
			wait_idle();
			chk("recal idle", tf_busy, 0);
			chk("recal status", v, {7'h28, t0_fail});
			rd(TF_ERR, r);
			chk("recal error", r, {6'h00, t0_fail, 1'b0});
		end
		$display("done: recalibrate");
		for (i = 0; i < 32; i++) begin
			pw_load = 1'b1;
			pw_master = i[4];
			pw_idx = 4'(i);
			pw_word = 16'($urandom);
			if (i[4])
				mpw[i % 16] = pw_word;
			else
				upw[i % 16] = pw_word;
			@(posedge clk);
			#1;
		end
		pw_load = 1'b0;
		for (i = 0; i < 6; i++) begin
			lock_set = 1'b1;
			@(posedge clk);
			#1 lock_set = 1'b0;
			lock = 1'b1;
			pw_cmd(pw_tab[i]);
		end
		$display("done: password disable");
		summarize();
	end

	initial begin
		#300us;
		fail_count++;
		summarize();
	end
endmodule : avr_cmd_top_tb
